/* File: include/swb_pkg.sv */
// Constants and types for the single-wire bit, pulse and search block
`default_nettype none
package swb_pkg;
	localparam int CLK_MHZ = 25;
	localparam int CNT_W = 24;
	// Slot timing in microseconds, regular and fast speed
	localparam int REG_SLOT_US = 65;
	localparam int REG_W0_US = 60;
	localparam int REG_W1_US = 8;
	localparam int REG_SMP_US = 15;
	localparam int OD_SLOT_US = 10;
	localparam int OD_W0_US = 8;
	localparam int OD_W1_US = 1;
	localparam int OD_SMP_US = 2;
	localparam logic [CNT_W-1:0] REG_SLOT_CYC = CNT_W'(REG_SLOT_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] REG_W0_CYC = CNT_W'(REG_W0_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] REG_W1_CYC = CNT_W'(REG_W1_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] REG_SMP_CYC = CNT_W'(REG_SMP_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] OD_SLOT_CYC = CNT_W'(OD_SLOT_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] OD_W0_CYC = CNT_W'(OD_W0_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] OD_W1_CYC = CNT_W'(OD_W1_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] OD_SMP_CYC = CNT_W'(OD_SMP_US * CLK_MHZ);
	// Reserved codes and fixed answers
	localparam logic [7:0] CODE_DATA_MODE = 8'he1;
	localparam logic [7:0] CODE_CMD_MODE = 8'he3;
	localparam logic [7:0] CODE_PULSE_END = 8'hf1;
	localparam logic [7:0] RSP_BIT_ONE = 8'hef;
	localparam logic [7:0] RSP_BIT_ZERO = 8'hec;
	localparam logic [7:0] RSP_ARM_ONE = 8'hf6;
	localparam logic [7:0] RSP_ARM_ZERO = 8'h76;
	// Command fields
	localparam logic [2:0] OPC_SINGLE = 3'h4;
	localparam logic [2:0] OPC_SEARCH = 3'h5;
	localparam logic [2:0] OPC_PULSE = 3'h7;
	localparam logic [1:0] SPD_FAST = 2'h2;
	localparam logic [1:0] SPD_PULSE = 2'h3;
	localparam int B_MARK = 0;
	localparam int B_PULL = 1;
	localparam int B_SPD = 2;
	localparam int B_TYPE = 4;
	localparam int B_OPC = 5;
	localparam int B_MSB = 7;
	localparam int FIFO_DEPTH = 8;
	localparam int SRCH_SLOTS = 12;
	typedef enum logic [1:0] {SWB_IDLE, SWB_SLOT, SWB_PULSE} swb_state_t;
	typedef enum logic [1:0] {SWB_CMD, SWB_DATA, SWB_CHECK} swb_mode_t;
	typedef enum logic [1:0] {SWB_JOB_BIT, SWB_JOB_BYTE, SWB_JOB_SRCH} swb_job_t;
endpackage
`default_nettype wire

/* File: design/swb_bridge.sv */
// Response FIFO and bit, pulse and search engine of the single-wire bridge
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module swb_fifo #(
	parameter int W = 8,
	parameter int D = swb_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData,
	output logic nearFull
);
	localparam int CW = $clog2(D) + 1;
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [CW-1:0] cnt;
		logic vld;
	} swb_fifo_regs_t;
	swb_fifo_regs_t q, d;
	logic [CW-1:0] n;
	assign inReady = q.cnt < CW'(D);
	// Slack of three words lets the engine finish a two-answer job
	assign nearFull = q.cnt > CW'(D - 3);
	assign outValid = q.vld;
	assign outData = q.mem[0];
	always_comb
	begin
		d = q;
		n = q.cnt;
		if (outReady && q.vld)
		begin
			for (int i = 0; i < D - 1; i++)
				d.mem[i] = q.mem[i + 1];
			n = n - 1'b1;
		end
		if (inValid && inReady)
		begin
			d.mem[n] = inData;
			n = n + 1'b1;
		end
		d.cnt = n;
		d.vld = n != '0;
	end
	always_ff @(posedge clk)
		if (!rst_n)
			q <= '0;
		else
			q <= d;
endmodule
////////////////////////////////////////////////////////////////////////////
module swb_bridge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	output logic rxReady,
	output logic txValid,
	input wire logic txReady,
	output logic [7:0] txData,
	input wire logic wireIn,
	output logic wireOut,
	output logic wireOe,
	output logic spuOn,
	output logic progOn,
	input wire logic vppPresent,
	input wire logic loadDrop,
	input wire logic [swb_pkg::CNT_W-1:0] pulseLen,
	output logic accelOn,
	output logic pullArmed,
	output logic [1:0] speedSel,
	output logic dataMode
);
	typedef struct packed {
		swb_pkg::swb_state_t st;
		swb_pkg::swb_mode_t mode;
		swb_pkg::swb_job_t job;
		logic [1:0] speed;
		logic accel, armed, srchErr;
		logic [swb_pkg::CNT_W-1:0] cnt;
		logic [2:0] bitIdx;
		logic [1:0] sub;
		logic [7:0] cmd, rd, pend, pushData;
		logic slotBit, smp, b0, progKind;
		logic [2:0] s1, s2;
		logic wireOut, wireOe, spu, prog, rxReady, push, dmode;
	} swb_regs_t;
	swb_regs_t q, d;
	logic rxFire, nearFull, fifoReady, execCmd, sendData, slotDone, pEnd;
	logic s, b2, dflag;
	logic [7:0] nrd;

	function automatic logic [swb_pkg::CNT_W-1:0] lowCyc(logic [1:0] spd,
		logic bv);
		if (spd == swb_pkg::SPD_FAST)
			return bv ? swb_pkg::OD_W1_CYC : swb_pkg::OD_W0_CYC;
		return bv ? swb_pkg::REG_W1_CYC : swb_pkg::REG_W0_CYC;
	endfunction
	function automatic logic [swb_pkg::CNT_W-1:0] smpCyc(logic [1:0] spd);
		return spd == swb_pkg::SPD_FAST ? swb_pkg::OD_SMP_CYC
			: swb_pkg::REG_SMP_CYC;
	endfunction
	function automatic logic [swb_pkg::CNT_W-1:0] endCyc(logic [1:0] spd);
		return spd == swb_pkg::SPD_FAST ? swb_pkg::OD_SLOT_CYC
			: swb_pkg::REG_SLOT_CYC;
	endfunction

	assign rxFire = rxValid && q.rxReady;
	assign slotDone = q.st == swb_pkg::SWB_SLOT
		&& q.cnt == endCyc(q.speed) - 1'b1;
	assign s = q.smp;
	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.push = 1'b0;
		d.s1 = {wireIn, vppPresent, loadDrop};
		d.s2 = q.s1;
		execCmd = 1'b0;
		sendData = 1'b0;
		pEnd = 1'b0;
		nrd = {s, q.rd[7:1]};
		// Search decision: conflict takes host path, silence forces one
		dflag = q.b0 == s;
		b2 = q.srchErr || (q.b0 && s) ? 1'b1
			: (dflag ? q.cmd[{q.bitIdx[1:0], 1'b1}] : q.b0);
		case (q.st)
		swb_pkg::SWB_IDLE:
			if (rxFire)
				case (q.mode)
				swb_pkg::SWB_CMD:
					if (rxData == swb_pkg::CODE_DATA_MODE)
						d.mode = swb_pkg::SWB_DATA;
					else
						execCmd = 1'b1;
				swb_pkg::SWB_DATA:
					if (rxData == swb_pkg::CODE_CMD_MODE)
						d.mode = swb_pkg::SWB_CHECK;
					else
						sendData = 1'b1;
				swb_pkg::SWB_CHECK:
					if (rxData == swb_pkg::CODE_CMD_MODE)
					begin
						d.mode = swb_pkg::SWB_DATA;
						sendData = 1'b1;
					end
					else
					begin
						d.mode = swb_pkg::SWB_CMD;
						execCmd = 1'b1;
					end
				default:
					d.mode = swb_pkg::SWB_CMD;
				endcase
		swb_pkg::SWB_SLOT:
		begin
			d.cnt = q.cnt + 1'b1;
			if (q.cnt == lowCyc(q.speed, q.slotBit) - 1'b1)
				d.wireOe = 1'b0;
			if (q.cnt == smpCyc(q.speed))
				d.smp = q.s2[2];
			if (slotDone)
			begin
				d.cnt = '0;
				d.st = swb_pkg::SWB_SLOT;
				d.wireOe = 1'b1;
				case (q.job)
				swb_pkg::SWB_JOB_BIT:
				begin
					d.push = 1'b1;
					d.pushData = {swb_pkg::OPC_SINGLE,
						q.cmd[swb_pkg::B_TYPE:swb_pkg::B_SPD], s, s};
					d.st = swb_pkg::SWB_IDLE;
					d.wireOe = 1'b0;
					if (q.cmd[swb_pkg::B_PULL])
					begin
						d.st = swb_pkg::SWB_PULSE;
						d.spu = 1'b1;
						d.progKind = 1'b0;
						d.pend = s ? swb_pkg::RSP_BIT_ONE
							: swb_pkg::RSP_BIT_ZERO;
					end
				end
				swb_pkg::SWB_JOB_BYTE:
				begin
					d.rd = nrd;
					d.bitIdx = q.bitIdx + 1'b1;
					d.slotBit = q.cmd[d.bitIdx];
					if (q.bitIdx == 3'h7)
					begin
						d.push = 1'b1;
						d.pushData = nrd;
						d.st = swb_pkg::SWB_IDLE;
						d.wireOe = 1'b0;
						if (q.armed)
						begin
							d.st = swb_pkg::SWB_PULSE;
							d.spu = 1'b1;
							d.progKind = 1'b0;
							d.pend = q.cmd[swb_pkg::B_MSB]
								? swb_pkg::RSP_ARM_ONE
								: swb_pkg::RSP_ARM_ZERO;
						end
					end
				end
				default:
				begin
					// Two read slots, then the chosen write slot
					d.sub = q.sub + 1'b1;
					d.slotBit = 1'b1;
					if (q.sub == 2'h0)
						d.b0 = s;
					else if (q.sub == 2'h1)
					begin
						d.slotBit = b2;
						d.rd[{q.bitIdx[1:0], 1'b1}] = b2;
						d.rd[{q.bitIdx[1:0], 1'b0}] = dflag;
						if (q.b0 && s)
							d.srchErr = 1'b1;
					end
					else
					begin
						d.sub = 2'h0;
						d.bitIdx = q.bitIdx + 1'b1;
						if (q.bitIdx == 3'h3)
						begin
							d.push = 1'b1;
							d.pushData = q.rd;
							d.st = swb_pkg::SWB_IDLE;
							d.wireOe = 1'b0;
						end
					end
				end
				endcase
			end
		end
		swb_pkg::SWB_PULSE:
		begin
			d.cnt = q.cnt + 1'b1;
			d.prog = q.progKind && q.s2[1];
			// Zero length means unlimited; host keeps it off while armed
			pEnd = (pulseLen != '0 && q.cnt == pulseLen - 1'b1)
				|| (!q.progKind && q.s2[0])
				|| (rxFire && q.mode == swb_pkg::SWB_CMD
				&& rxData == swb_pkg::CODE_PULSE_END);
			if (pEnd)
			begin
				d.spu = 1'b0;
				d.prog = 1'b0;
				d.push = 1'b1;
				d.pushData = q.pend;
				d.st = swb_pkg::SWB_IDLE;
			end
		end
		default:
			d.st = swb_pkg::SWB_IDLE;
		endcase
		if (execCmd && rxData[swb_pkg::B_MARK])
			case (rxData[7:swb_pkg::B_OPC])
			swb_pkg::OPC_SINGLE:
			begin
				d.speed = rxData[3:swb_pkg::B_SPD];
				d.cmd = rxData;
				d.job = swb_pkg::SWB_JOB_BIT;
				d.slotBit = rxData[swb_pkg::B_TYPE];
				d.st = swb_pkg::SWB_SLOT;
				d.cnt = '0;
				d.wireOe = 1'b1;
			end
			swb_pkg::OPC_SEARCH:
				if (!rxData[swb_pkg::B_PULL])
				begin
					// Latched until changed or reset; no answer queued
					d.accel = rxData[swb_pkg::B_TYPE];
					d.speed = rxData[3:swb_pkg::B_SPD];
					if (!rxData[swb_pkg::B_TYPE])
						d.srchErr = 1'b0;
				end
			swb_pkg::OPC_PULSE:
				if (rxData[3:swb_pkg::B_SPD] == swb_pkg::SPD_PULSE)
				begin
					// Arming with a programming pulse is the host's risk
					d.armed = rxData[swb_pkg::B_PULL];
					d.progKind = rxData[swb_pkg::B_TYPE];
					d.spu = !rxData[swb_pkg::B_TYPE];
					d.pend = {rxData[7:swb_pkg::B_SPD], 2'h0};
					d.st = swb_pkg::SWB_PULSE;
					d.cnt = '0;
				end
			default:
				d.st = q.st;
			endcase
		if (sendData)
		begin
			// Accelerator assumes pullup disarmed by the host
			d.cmd = rxData;
			d.bitIdx = '0;
			d.sub = '0;
			d.rd = '0;
			d.job = q.accel ? swb_pkg::SWB_JOB_SRCH
				: swb_pkg::SWB_JOB_BYTE;
			d.slotBit = q.accel ? 1'b1 : rxData[0];
			d.st = swb_pkg::SWB_SLOT;
			d.cnt = '0;
			d.wireOe = 1'b1;
		end
		// One job at a time and three words of slack keep the queue safe
		d.rxReady = !nearFull && (d.st == swb_pkg::SWB_IDLE
			|| (d.st == swb_pkg::SWB_PULSE && d.mode == swb_pkg::SWB_CMD));
		// Registered copy keeps the mode output glitch free
		d.dmode = d.mode != swb_pkg::SWB_CMD;
	end
	always_ff @(posedge clk)
		if (!rst_n)
			q <= '0;
		else
			q <= d;

	swb_fifo #(.W(8), .D(swb_pkg::FIFO_DEPTH)) swb_fifo_i (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(q.push),
		.inReady(fifoReady),
		.inData(q.pushData),
		.outValid(txValid),
		.outReady(txReady),
		.outData(txData),
		.nearFull(nearFull)
	);
	assign rxReady = q.rxReady;
	assign wireOut = q.wireOut;
	assign wireOe = q.wireOe;
	assign spuOn = q.spu;
	assign progOn = q.prog;
	assign accelOn = q.accel;
	assign pullArmed = q.armed;
	assign speedSel = q.speed;
	assign dataMode = q.dmode;
	////////////////////////////////////////////////////////////////////////
	logic [3:0] slotCnt;
	always_ff @(posedge clk)
		if (!rst_n || sendData)
			slotCnt <= '0;
		else if (slotDone)
			slotCnt <= slotCnt + 1'b1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence seqSrchCmd;
		rxFire && q.st == swb_pkg::SWB_IDLE && q.mode == swb_pkg::SWB_CMD
			&& rxData[7:swb_pkg::B_OPC] == swb_pkg::OPC_SEARCH
			&& !rxData[swb_pkg::B_PULL] && rxData[swb_pkg::B_MARK];
	endsequence
	sequence seqPullEnd;
		q.st == swb_pkg::SWB_PULSE && pEnd;
	endsequence
	chk_slot_low_len: assert property (
		q.st == swb_pkg::SWB_SLOT && q.cnt == lowCyc(q.speed, q.slotBit)
		|-> !q.wireOe) else $error("slot low time wrong");
	chk_bit_answer: assert property (
		slotDone && q.job == swb_pkg::SWB_JOB_BIT |=> q.push
		&& q.pushData[7:5] == swb_pkg::OPC_SINGLE
		&& q.pushData[4:2] == $past(q.cmd[4:2])
		&& q.pushData[1] == q.pushData[0]) else $error("bad bit answer");
	chk_bit_pullup: assert property (
		slotDone && q.job == swb_pkg::SWB_JOB_BIT
		|=> q.spu == $past(q.cmd[swb_pkg::B_PULL]))
		else $error("pullup after bit wrong");
	chk_pulse_answer: assert property (
		seqPullEnd |=> q.push && q.pushData == $past(q.pend)
		&& !q.spu && !q.prog) else $error("pulse end answer missing");
	chk_accel_load: assert property (
		seqSrchCmd |=> q.accel == $past(rxData[4])
		&& q.speed == $past(rxData[3:2]) ##1 !q.push)
		else $error("accelerator command wrong");
	chk_prog_supply: assert property (
		q.prog |-> $past(q.s2[1])) else $error("pulse without supply");
	chk_early_end: assert property (
		rxFire && q.st == swb_pkg::SWB_PULSE && q.mode == swb_pkg::SWB_CMD
		&& rxData == swb_pkg::CODE_PULSE_END |=> !q.spu && !q.prog)
		else $error("pulse not ended by host");
	chk_srch_slots: assert property (
		q.push && q.job == swb_pkg::SWB_JOB_SRCH && q.st == swb_pkg::SWB_IDLE
		|-> slotCnt == 4'(swb_pkg::SRCH_SLOTS)) else $error("not 12 slots");
	chk_arm_follow: assert property (
		slotDone && q.job == swb_pkg::SWB_JOB_BYTE && q.bitIdx == 3'h7
		&& q.armed |=> q.spu && q.st == swb_pkg::SWB_PULSE)
		else $error("armed pullup missing");
	chk_mode_enter: assert property (
		rxFire && q.st == swb_pkg::SWB_IDLE && q.mode == swb_pkg::SWB_CMD
		&& rxData == swb_pkg::CODE_DATA_MODE |=> q.mode == swb_pkg::SWB_DATA)
		else $error("no switch to data mode");
	chk_fifo_room: assert property (
		q.push |-> fifoReady) else $error("answer pushed into full queue");
endmodule
`default_nettype wire

/* File: verification/swb_slave_model.sv */
// Behavioural slave device on the single-wire bus
`default_nettype none
module swb_slave_model (
	input wire logic wireOe,
	input wire logic fastSpeed,
	input wire logic replyBit,
	output logic wireIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic holdLow = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Slave answers 0 by holding the line low past the sample point
	always @(posedge wireOe)
	begin
		// Speed latch updates in the same step as the slot start
		#1;
		if (!replyBit)
		begin
			holdLow = 1'b1;
			// Short hold at fast speed, or it would spill into the next slot
			if (fastSpeed)
				#2999 holdLow = 1'b0;
			else
				#29999 holdLow = 1'b0;
		end
	end
	// Pull-up resistor: a released line reads high
	assign wireIn = !(wireOe || holdLow);
endmodule
`default_nettype wire

/* File: verification/tb_single_wire_bit_pulse_search_cmds.sv */
// Self-checking bench for the bit, pulse and search engine
`default_nettype none
module tb_single_wire_bit_pulse_search_cmds;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, rxValid, rxReady, txValid, txReady, wireIn, wireOut;
	logic wireOe, spuOn, progOn, vppPresent, loadDrop, accelOn, pullArmed;
	logic dataMode, replyBit, oePrev, bb;
	logic [7:0] rxData, txData, seed, cmd, d;
	logic [1:0] speedSel;
	logic [swb_pkg::CNT_W-1:0] pulseLen;
	logic [7:0] rspQ[$];
	logic [7:0] expQ[$];
	int n_fail, n_checks, nSlots, progCnt, s0, p0, i;
	swb_bridge swb_bridge_i (.clk(clk), .rst_n(rst_n), .rxValid(rxValid),
		.rxData(rxData), .rxReady(rxReady), .txValid(txValid),
		.txReady(txReady), .txData(txData), .wireIn(wireIn),
		.wireOut(wireOut), .wireOe(wireOe), .spuOn(spuOn), .progOn(progOn),
		.vppPresent(vppPresent), .loadDrop(loadDrop), .pulseLen(pulseLen),
		.accelOn(accelOn), .pullArmed(pullArmed), .speedSel(speedSel),
		.dataMode(dataMode));
	swb_slave_model swb_slave_model_i (.wireOe(wireOe),
		.fastSpeed(speedSel == swb_pkg::SPD_FAST), .replyBit(replyBit),
		.wireIn(wireIn));
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Monitors: answer bytes, slot starts, programming cycles
	always @(posedge clk)
	begin
		oePrev <= wireOe;
		if (rst_n && txValid && txReady)
			rspQ.push_back(txData);
		if (wireOe && !oePrev)
			nSlots <= nSlots + 1;
		if (progOn === 1'b1)
			progCnt <= progCnt + 1;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Search answer: all positions in conflict, or bus silent
	function automatic logic [7:0] srch_exp(input logic [7:0] path,
		input logic fail);
		return fail ? 8'hff : (path & 8'haa) | 8'h55;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready();
		int k;
		k = 0;
		repeat (3) @(negedge clk);
		while (rxReady !== 1'b1 && k < 40000)
		begin
			@(negedge clk);
			k++;
		end
		if (k >= 40000)
			n_fail++;
	endtask
	// Byte held until the edge that finds rxReady high
	task automatic send(input logic [7:0] v);
		int k;
		k = 0;
		@(negedge clk);
		rxData = v;
		rxValid = 1'b1;
		while (rxReady !== 1'b1 && k < 40000)
		begin
			@(negedge clk);
			k++;
		end
		if (k >= 40000)
			n_fail++;
		@(posedge clk);
		@(negedge clk);
		rxValid = 1'b0;
	endtask
	task automatic expect_rsp(input logic [7:0] exp, input logic [7:0] mask);
		int k;
		k = 0;
		while (rspQ.size() == 0 && k < 40000)
		begin
			@(negedge clk);
			k++;
		end
		chk(rspQ.size() == 0 ? 8'hxx : rspQ.pop_front() & mask, exp & mask);
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		// Roughly twice the expected length of the run
		repeat (60000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
	initial
	begin
		rst_n = 1'b0;
		rxValid = 1'b0;
		rxData = 8'h00;
		txReady = 1'b0;
		replyBit = 1'b1;
		vppPresent = 1'b0;
		loadDrop = 1'b0;
		pulseLen = 24'h000064;
		seed = 8'h24;
		oePrev = 1'b0;
		nSlots = 0;
		progCnt = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk({accelOn, pullArmed, speedSel, dataMode, spuOn, progOn, wireOut},
			8'h00);
		// Singles at every speed; answers pile up while the far side stalls
		for (i = 0; i < 6; i++)
		begin
			wait_ready();
			seed = lfsr(seed);
			cmd = 8'h81 | 8'((i % 4) << 2) | (seed & 8'h10);
			replyBit = seed[7];
			bb = cmd[4] & seed[7];
			expQ.push_back({3'h4, cmd[4:2], bb, bb});
			send(cmd);
			if (i % 4 != 3)
				chk({6'h00, speedSel}, {6'h00, cmd[3:2]});
		end
		repeat (2000) @(negedge clk);
		chk({7'h00, rxReady}, 8'h00);
		txReady = 1'b1;
		while (expQ.size() > 0)
			expect_rsp(expQ.pop_front(), 8'hff);
		// Unlimited 5V pullup ended by loadDrop, then by F1h
		pulseLen = 24'h000000;
		for (i = 0; i < 2; i++)
		begin
			send(8'hed);
			repeat (50) @(negedge clk);
			chk({7'h00, spuOn}, 8'h01);
			if (i == 1)
				send(swb_pkg::CODE_PULSE_END);
			else
			begin
				loadDrop = 1'b1;
				repeat (5) @(negedge clk);
				loadDrop = 1'b0;
			end
			expect_rsp(8'hed, 8'hfc);
			chk({6'h00, spuOn, pullArmed}, 8'h00);
		end
		// Programming pulse with and without supply
		pulseLen = 24'h000064;
		for (i = 0; i < 2; i++)
		begin
			vppPresent = i[0];
			p0 = progCnt;
			send(8'hfd);
			expect_rsp(8'hfd, 8'hfc);
			chk({7'h00, progCnt != p0}, {7'h00, i[0]});
		end
		vppPresent = 1'b0;
		send(8'hef);
		expect_rsp(8'hef, 8'hfc);
		chk({7'h00, pullArmed}, 8'h01);
		// Single bit followed by strong pullup
		seed = lfsr(seed);
		replyBit = seed[0];
		send(8'h93);
		expect_rsp({6'h24, seed[0], seed[0]}, 8'hff);
		chk({7'h00, spuOn}, 8'h01);
		expect_rsp(seed[0] ? swb_pkg::RSP_BIT_ONE : swb_pkg::RSP_BIT_ZERO, 8'hff);
		// Armed data byte; bit 6 kept low so it never matches E3h
		send(swb_pkg::CODE_DATA_MODE);
		chk({7'h00, dataMode}, 8'h01);
		replyBit = 1'b1;
		seed = lfsr(seed);
		d = {seed[7], 1'b0, seed[5:0]};
		send(d);
		expect_rsp(d, 8'hff);
		chk({7'h00, spuOn}, 8'h01);
		expect_rsp(d[7] ? swb_pkg::RSP_ARM_ONE : swb_pkg::RSP_ARM_ZERO, 8'hff);
		// Back through check mode; disarm before the accelerator
		send(swb_pkg::CODE_CMD_MODE);
		send(8'hed);
		expect_rsp(8'hed, 8'hfc);
		chk({6'h00, dataMode, pullArmed}, 8'h00);
		send(8'hb9);
		repeat (20) @(negedge clk);
		chk(8'(rspQ.size()), 8'h00);
		chk({5'h00, accelOn, speedSel}, 8'h06);
		send(swb_pkg::CODE_DATA_MODE);
		// Slave pulls every slot low: conflict everywhere, host path taken
		replyBit = 1'b0;
		seed = lfsr(seed);
		d = seed & 8'haa;
		send(d);
		expect_rsp(srch_exp(d, 1'b0), 8'hff);
		// Silent bus: every position is an error, all ones come back
		replyBit = 1'b1;
		s0 = nSlots;
		send(8'h00);
		expect_rsp(srch_exp(8'h00, 1'b1), 8'hff);
		chk(8'(nSlots - s0), 8'h0c);
		send(swb_pkg::CODE_CMD_MODE);
		send(8'ha1);
		repeat (20) @(negedge clk);
		chk({5'h00, accelOn, speedSel}, 8'h00);
		chk(8'(rspQ.size()), 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
